/* hw/irq_readback_params.svh */
/*
 Offsets, field positions, reset values and timing counts for the
 interrupt status readback block. Assumes 32-bit APB byte addressing.
*/
`ifndef IRQ_READBACK_PARAMS_SVH
`define IRQ_READBACK_PARAMS_SVH

// Register byte offsets
`define OFS_FAST_IRQ_VECTOR 12'h104
`define OFS_IRQ_STATUS 12'h108
`define OFS_IRQ_PENDING 12'h10c
`define OFS_IRQ_MASK 12'h110
`define OFS_CORE_IRQ_LINE_STATUS 12'h114
`define OFS_EVENT_STATUS 12'h140
`define OFS_EVENT_CLEAR 12'h144
`define OFS_EVENT_ENABLE 12'h148
`define ADDR_W 12

// Field positions
`define SRC_NUM_LSB 0
`define PRIO_LSB 5
`define FAST_LINE_BIT 0
`define NORMAL_LINE_BIT 1
`define EXT0_BIT 10
`define UNUSED_SRC_BIT 11

// Reset values and masks
`define FAST_VECTOR_VALUE 32'h0000_0000
`define SRC_VALID_MASK 16'hf7ff
`define EXT_SRC_MASK 16'h0400
`define EVT_W 4
`define EVT_RESET 4'h0

// Timing: answer after one access cycle
`define ACCESS_CYCLES 1

`endif

/* hw/irq_readback_pkg.sv */
/*
 Types for the interrupt status readback block.
 Assumes the parameter header is on the include path.
*/
package irq_readback_pkg;

    // One bit per interrupt source, bit 15 first
    typedef struct packed {
        logic gpio_b_source_bit;
        logic serial_b_source_bit;
        logic dsp_b_source_bit;
        logic dsp_a_source_bit;
        logic unused_source_bit;
        logic external0_source_bit;
        logic serial_periph_source_bit;
        logic display_source_bit;
        logic gpio_a_source_bit;
        logic timer2_source_bit;
        logic timer1_source_bit;
        logic timer0_source_bit;
        logic serial_a_source_bit;
        logic software_source_bit;
        logic watchdog_source_bit;
        logic fast_source_bit;
    } src_map_type;

    // Sticky event bits, bit 3 first
    typedef struct packed {
        logic vector_read;
        logic fast_pending_rise;
        logic normal_line_rise;
        logic fast_line_rise;
    } event_type;

endpackage : irq_readback_pkg

/* hw/irq_status_readback.sv */
/*
 APB readback of fast vector, serviced interrupt, pending map, mask and
 core request line state, with a small sticky event interrupt.
 Assumes the rest of the controller drives the live pending map, mask,
 serviced number and priority, and the two core request lines, all
 synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_readback_params.svh"

module irq_status_readback
    import irq_readback_pkg::*;
#(
    parameter int NUM_SRC = 16,
    parameter int PRIO_W = 3,
    parameter int NUM_W = 5
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller state
    input wire src_map_type pending_in,
    input wire src_map_type mask_in,
    input wire logic [NUM_W-1:0] current_source_number,
    input wire logic [PRIO_W-1:0] current_priority,
    input wire logic fast_request_line,
    input wire logic normal_request_line,
    input wire logic external0_level,
    // Controller commands and interrupt
    output logic fast_cancel,
    output logic irq_out
);

    // Elaboration check on widths the logic serves
    if (NUM_SRC != 16 || PRIO_W != 3 || NUM_W != 5) begin : g_bad_width
        $error("irq_status_readback: unsupported width parameters");
    end

    // Address decode shared by read and write paths
    function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
        is_mapped = (a == `OFS_FAST_IRQ_VECTOR) || (a == `OFS_IRQ_STATUS) ||
                    (a == `OFS_IRQ_PENDING) || (a == `OFS_IRQ_MASK) ||
                    (a == `OFS_CORE_IRQ_LINE_STATUS) || (a == `OFS_EVENT_STATUS) ||
                    (a == `OFS_EVENT_CLEAR) || (a == `OFS_EVENT_ENABLE);
    endfunction : is_mapped

    logic [`ADDR_W-1:0] addr;
    logic setup;
    logic access_done;
    logic started;
    src_map_type pending;
    src_map_type mask;
    logic [PRIO_W-1:0] prio_q;
    logic [NUM_W-1:0] num_q;
    logic fast_line_q;
    logic normal_line_q;
    logic fast_pend_q;
    event_type evt_status;
    event_type evt_enable;
    event_type evt_set;
    event_type evt_clr;
    logic [31:0] next_prdata;

    assign addr = paddr[`ADDR_W-1:0];
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready;

    // First cycle after reset release marker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // Pending map capture, external bit taken from line at release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= '0;
        end else if (!started) begin
            pending <= src_map_type'(external0_level ? `EXT_SRC_MASK : 16'h0000);
        end else begin
            pending <= src_map_type'(pending_in & `SRC_VALID_MASK);
        end
    end

    // Mask copy, zero out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= '0;
        end else begin
            mask <= src_map_type'(mask_in & `SRC_VALID_MASK);
        end
    end

    // Serviced interrupt and core line snapshots
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_q <= '0;
            num_q <= '0;
            fast_line_q <= 1'b0;
            normal_line_q <= 1'b0;
            fast_pend_q <= 1'b0;
        end else begin
            prio_q <= current_priority;
            num_q <= current_source_number;
            fast_line_q <= fast_request_line;
            normal_line_q <= normal_request_line;
            fast_pend_q <= pending.fast_source_bit;
        end
    end

    // Read data mux evaluated in the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (addr)
            `OFS_FAST_IRQ_VECTOR: next_prdata = `FAST_VECTOR_VALUE;
            `OFS_IRQ_STATUS: begin
                next_prdata[`PRIO_LSB +: PRIO_W] = prio_q;
                next_prdata[`SRC_NUM_LSB +: NUM_W] = num_q;
            end
            `OFS_IRQ_PENDING: next_prdata[NUM_SRC-1:0] = pending;
            `OFS_IRQ_MASK: next_prdata[NUM_SRC-1:0] = mask;
            `OFS_CORE_IRQ_LINE_STATUS: begin
                next_prdata[`FAST_LINE_BIT] = fast_line_q;
                next_prdata[`NORMAL_LINE_BIT] = normal_line_q;
            end
            `OFS_EVENT_STATUS: next_prdata[`EVT_W-1:0] = evt_status;
            `OFS_EVENT_ENABLE: next_prdata[`EVT_W-1:0] = evt_enable;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // APB answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !is_mapped(addr);
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // Fast vector read cancels the fast request, one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cancel <= 1'b0;
        end else begin
            fast_cancel <= access_done && !pwrite && (addr == `OFS_FAST_IRQ_VECTOR);
        end
    end

    // Event sources and software clear strobe
    always_comb begin
        evt_set.vector_read = access_done && !pwrite && (addr == `OFS_FAST_IRQ_VECTOR);
        evt_set.fast_pending_rise = pending.fast_source_bit && !fast_pend_q;
        evt_set.normal_line_rise = normal_request_line && !normal_line_q;
        evt_set.fast_line_rise = fast_request_line && !fast_line_q;
        evt_clr = (access_done && pwrite && (addr == `OFS_EVENT_CLEAR)) ?
                  event_type'(pwdata[`EVT_W-1:0]) : event_type'(`EVT_RESET);
    end

    // Sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= event_type'(`EVT_RESET);
        end else begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
        end
    end

    // Event enable register, the only one that stores written data; event clear is a write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_enable <= event_type'(`EVT_RESET);
        end else if (access_done && pwrite && (addr == `OFS_EVENT_ENABLE)) begin
            evt_enable <= event_type'(pwdata[`EVT_W-1:0]);
        end
    end

    // Level interrupt from enabled sticky bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |((evt_status & ~evt_clr | evt_set) & evt_enable);
        end
    end

    // Checks
    sequence s_setup_read(logic [`ADDR_W-1:0] a);
        psel && !penable && !pwrite && (addr == a);
    endsequence

    sequence s_zero_answer;
        pready && (prdata == 32'h0000_0000);
    endsequence

    chk_vector_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_read(`OFS_FAST_IRQ_VECTOR) |=> s_zero_answer ##1 fast_cancel)
        else $error("fast vector read not zero or not cancelled");

    chk_cancel_cause: assert property (@(posedge pclk) disable iff (!presetn)
        fast_cancel |-> $past(access_done) && !$past(pwrite))
        else $error("fast cancel without a vector read");

    chk_status_fields: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_read(`OFS_IRQ_STATUS) |=> prdata == {24'h0, $past(prio_q), $past(num_q)})
        else $error("serviced number or priority wrong");

    chk_pending_map: assert property (@(posedge pclk) disable iff (!presetn)
        started && $past(started) |-> pending == ($past(pending_in) & `SRC_VALID_MASK))
        else $error("pending map not following controller");

    chk_mask_reset: assert property (@(posedge pclk)
        !started |-> mask == '0)
        else $error("mask not zero out of reset");

    chk_fast_line: assert property (@(posedge pclk) disable iff (!presetn)
        started ##0 s_setup_read(`OFS_CORE_IRQ_LINE_STATUS)
        |=> prdata[`FAST_LINE_BIT] == $past(fast_request_line, 2))
        else $error("fast line status wrong");

    chk_normal_line: assert property (@(posedge pclk) disable iff (!presetn)
        started ##0 s_setup_read(`OFS_CORE_IRQ_LINE_STATUS)
        |=> prdata[`NORMAL_LINE_BIT] == $past(normal_request_line, 2))
        else $error("normal line status wrong");

    chk_reset_pending: assert property (@(posedge pclk) disable iff (!presetn)
        !started |=> (pending & ~`EXT_SRC_MASK) == 16'h0000
        && pending.external0_source_bit == $past(external0_level))
        else $error("pending not set up from lines at reset release");

    chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pslverr && $past(addr) != `OFS_FAST_IRQ_VECTOR &&
        $past(addr) != `OFS_IRQ_STATUS |-> prdata[31:NUM_SRC] == 16'h0000
        && !prdata[`UNUSED_SRC_BIT])
        else $error("unused bits not zero");

    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (evt_status & evt_enable) != '0 && evt_clr == '0 |=> irq_out)
        else $error("interrupt not raised for enabled event");

    chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a one-cycle answer");

    chk_idle_data: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("read data or error outside the answer");

    chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !is_mapped(addr) |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    chk_mask_map: assert property (@(posedge pclk) disable iff (!presetn)
        started |=> mask == ($past(mask_in) & `SRC_VALID_MASK))
        else $error("mask not following controller");

    chk_cancel_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        fast_cancel |=> !fast_cancel)
        else $error("fast cancel longer than one cycle");

    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        evt_set.vector_read |=> evt_status.vector_read)
        else $error("vector read event lost");

    chk_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        access_done && pwrite && addr == `OFS_EVENT_ENABLE
        |=> evt_enable == $past(pwdata[`EVT_W-1:0]))
        else $error("event enable write not taken");

endmodule : irq_status_readback

`default_nettype wire

/* sim/ctrl_model.sv */
/*
 Model of the rest of the controller: sticky pending map, mask and the
 two core request lines. Assumes the bench pulses raise_src for a cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module ctrl_model
    import irq_readback_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench stimulus
    input wire src_map_type raise_src,
    input wire src_map_type enable_src,
    input wire logic ext0_level,
    input wire logic fast_cancel,
    // Controller state
    output var src_map_type pending_in,
    output var src_map_type mask_in,
    output var logic fast_request_line,
    output var logic normal_request_line
);
    src_map_type pend_q;

    // Sticky pending, fast bit dropped on cancel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q | raise_src) & ~{15'h0, fast_cancel};
        end
    end

    // External line 0 is level sensitive, so it shows even through reset
    assign pending_in = src_map_type'(pend_q | {5'h00, ext0_level, 10'h000});

    // Mask and request lines
    assign mask_in = enable_src;
    assign fast_request_line = pending_in[0] & mask_in[0];
    assign normal_request_line = |(pending_in[15:1] & mask_in[15:1]);
endmodule : ctrl_model

`default_nettype wire

/* sim/irq_status_readback_tb.sv */
/*
 Self-checking bench for the status readback block.
 Assumes the design package and parameter header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_readback_params.svh"

module irq_status_readback_tb
    import irq_readback_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic pready, pslverr, fast_cancel, irq_out, fast_line, normal_line, er;
    logic ext0 = 1'b0;
    logic [4:0] cur_num = '0;
    logic [2:0] cur_prio = '0;
    src_map_type raise_src = '0, enable_src = '0, pending_in, mask_in;
    int num_errors = 0, cmp_count = 0;

    // Clock
    always #12.5 pclk = ~pclk;

    irq_status_readback u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pending_in(pending_in),
        .mask_in(mask_in), .current_source_number(cur_num), .current_priority(cur_prio),
        .fast_request_line(fast_line), .normal_request_line(normal_line),
        .external0_level(ext0), .fast_cancel(fast_cancel), .irq_out(irq_out));

    ctrl_model u_ctrl (.pclk(pclk), .presetn(presetn), .raise_src(raise_src), .ext0_level(ext0),
        .enable_src(enable_src), .fast_cancel(fast_cancel), .pending_in(pending_in),
        .mask_in(mask_in), .fast_request_line(fast_line), .normal_request_line(normal_line));

    task end_of_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read");
    endtask : rd_chk

    task wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n

    task t_reset;
        rd_chk(`OFS_FAST_IRQ_VECTOR, 32'h0);
        rd_chk(`OFS_IRQ_PENDING, 32'h0);
        rd_chk(`OFS_IRQ_MASK, 32'h0);
        rd_chk(`OFS_CORE_IRQ_LINE_STATUS, 32'h0);
    endtask : t_reset

    task t_status;
        cur_num <= 5'h1f;
        cur_prio <= 3'h7;
        wait_n(2);
        rd_chk(`OFS_IRQ_STATUS, 32'hff);
        cur_num <= 5'h0a;
        cur_prio <= 3'h2;
        wait_n(2);
        rd_chk(`OFS_IRQ_STATUS, 32'h4a);
    endtask : t_status

    task t_pend;
        enable_src <= 16'hffff;
        raise_src <= 16'hffff;
        @(posedge pclk);
        raise_src <= '0;
        wait_n(3);
        rd_chk(`OFS_IRQ_PENDING, 32'hf7ff);
        rd_chk(`OFS_IRQ_MASK, 32'hf7ff);
        rd_chk(`OFS_CORE_IRQ_LINE_STATUS, 32'h3);
        apb(1'b1, `OFS_IRQ_PENDING, 32'hffffffff);
        rd_chk(`OFS_IRQ_PENDING, 32'hf7ff);
        enable_src <= 16'h0001;
        wait_n(3);
        rd_chk(`OFS_IRQ_MASK, 32'h1);
        rd_chk(`OFS_CORE_IRQ_LINE_STATUS, 32'h1);
        enable_src <= 16'hffff;
        wait_n(3);
    endtask : t_pend

    task t_fast;
        rd_chk(`OFS_FAST_IRQ_VECTOR, 32'h0);
        @(posedge pclk);
        chk({31'h0, fast_cancel}, 32'h1, "cancel");
        wait_n(3);
        rd_chk(`OFS_IRQ_PENDING, 32'hf7fe);
        rd_chk(`OFS_CORE_IRQ_LINE_STATUS, 32'h2);
    endtask : t_fast

    // Events raise, mask and clear the interrupt; unmapped access errors
    task t_irq;
        rd_chk(`OFS_EVENT_STATUS, 32'hf);
        apb(1'b1, `OFS_EVENT_ENABLE, 32'hf);
        wait_n(2);
        chk({31'h0, irq_out}, 32'h1, "irq on");
        apb(1'b1, `OFS_EVENT_ENABLE, 32'h0);
        wait_n(2);
        chk({31'h0, irq_out}, 32'h0, "irq masked");
        apb(1'b1, `OFS_EVENT_CLEAR, 32'hf);
        rd_chk(`OFS_EVENT_STATUS, 32'h0);
        apb(1'b1, `OFS_EVENT_ENABLE, 32'hf);
        wait_n(2);
        chk({31'h0, irq_out}, 32'h0, "irq cleared");
        rd_chk(12'h200, 32'h0);
        chk({31'h0, er}, 32'h1, "slverr");
    endtask : t_irq

    // Mid-run reset with external line 0 high and mask cleared
    task t_ext_reset;
        enable_src <= '0;
        ext0 <= 1'b1;
        presetn <= 1'b0;
        wait_n(2);
        presetn <= 1'b1;
        rd_chk(`OFS_IRQ_PENDING, 32'h400);
        rd_chk(`OFS_IRQ_MASK, 32'h0);
        rd_chk(`OFS_EVENT_STATUS, 32'h0);
        ext0 <= 1'b0;
    endtask : t_ext_reset

    // Main sequence
    initial begin
        wait_n(4);
        presetn <= 1'b1;
        t_reset;
        t_status;
        t_pend;
        t_fast;
        t_irq;
        t_ext_reset;
        end_of_test;
    end

    // Watchdog
    initial begin
        wait_n(2000);
        num_errors++;
        $display("unexpected %0t watchdog timeout", $time);
        end_of_test;
    end
endmodule : irq_status_readback_tb

`default_nettype wire
